// ==== kpd_pkg.sv ====
// Purpose: Shared constants for the keypad entry decoder
// Assumes: 125 MHz clock, AHB-Lite register access
// Notes:   Offsets are byte addresses of 32-bit words
`default_nettype none
package kpd_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] KPD_CTRL_ADDR    = 8'h00;
  localparam logic [7:0] KPD_TEN_VAL_ADDR = 8'h04;
  localparam logic [7:0] KPD_TEN_IND_ADDR = 8'h08;
  localparam logic [7:0] KPD_MAT_VAL_ADDR = 8'h0c;
  localparam logic [7:0] KPD_MAT_IND_ADDR = 8'h10;
  localparam logic [7:0] KPD_STATUS_ADDR  = 8'h14;

  // ==========================================================
  // Control fields
  localparam int KPD_CTRL_TEN_EN  = 0;
  localparam int KPD_CTRL_MAT_EN  = 1;
  localparam int KPD_CTRL_WIDE    = 2;
  localparam int KPD_CTRL_HEX     = 3;
  localparam logic [3:0] KPD_CTRL_RESET = 4'h0;

  // ==========================================================
  // Matrix indicator fields
  localparam int KPD_IND_ANY_FUNC  = 6;
  localparam int KPD_IND_ANY_DIGIT = 7;

  // ==========================================================
  // Decimal limits: value kept before the next digit is appended
  localparam logic [31:0] KPD_DEC_KEEP_NARROW = 32'h0000_03e8;
  localparam logic [31:0] KPD_DEC_KEEP_WIDE   = 32'h0098_9680;
  localparam logic [31:0] KPD_DEC_BASE        = 32'h0000_000a;

  // ==========================================================
  // Scan timing
  localparam int KPD_CLK_PERIOD_NS = 8;
  localparam int KPD_SCAN_STEP_NS  = 1000;
  localparam int KPD_STEP_CYCLES   =
    (KPD_SCAN_STEP_NS + KPD_CLK_PERIOD_NS - 1) / KPD_CLK_PERIOD_NS;
  localparam logic [6:0] KPD_STEP_LAST = 7'(KPD_STEP_CYCLES - 1);

endpackage : kpd_pkg

`default_nettype wire

// ==== kpd_decoder.sv ====
// Purpose: Ten-key and 4x4 matrix keypad entry with AHB-Lite registers
// Assumes: Key inputs synchronous to CLK, single word transfers
// Notes:   Matrix lines are active high, one column per scan step
//
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Ten inputs are decimal digit keys 0-9
// - Keyed digits build a four or eight-digit number
// - Result held as plain binary integer
// - Narrow form drops leading digit past 9999
// - Eleven read-only ten-key indicator bits
// - Last pressed key indicator stays until another
// - Eleventh bit high while any digit pressed
// - Disabled ten-key clears all indicator bits
// - Disabling keeps the accumulated result
// - Four driven lines, four read lines, 16 keys
// - Simultaneous matrix keys: smallest value wins
// - Narrow matrix form keeps four digits
// - Wide matrix form keeps eight digits
// - Scan-complete flag high one scan step
// - Hex mode accumulates all sixteen keys
// - Decimal mode: A-F are function keys
// - New function key replaces latched one
// - Earliest held function key keeps priority
// - Any A-F and any 0-9 indicators
// - Disabled matrix clears indicators, keeps result
module kpd_decoder
  import kpd_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output var  logic [31:0] HRDATA,
  output var  logic        HREADYOUT,
  output var  logic        HRESP,
  input  wire logic [9:0]  TEN_KEY,
  input  wire logic [3:0]  MATRIX_IN,
  output var  logic [3:0]  MATRIX_OUT,
  output var  logic        SCAN_COMPLETE
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [3:0]  ctrl;
    logic [9:0]  ten_prev;
    logic [31:0] ten_val;
    logic [10:0] ten_ind;
    logic [15:0] mat_prev;
    logic [15:0] mat_cur;
    logic [31:0] mat_val;
    logic [7:0]  mat_ind;
    logic [1:0]  col;
    logic [6:0]  step_cnt;
    logic        done;
    logic [3:0]  col_out;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        wr_pend;
    logic [7:0]  wr_addr;
  } kpd_state_t;

  kpd_state_t st;
  kpd_state_t next_st;

  // ==========================================================
  // Functions

  // Lowest set bit wins; bit 4 of the answer flags a hit
  function automatic logic [4:0] kpd_lowest(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : kpd_lowest

  // Append one digit; the modulo drops the leading digit on overflow
  function automatic logic [31:0] kpd_accum(input logic [31:0] val,
                                            input logic [3:0]  d,
                                            input logic        wide,
                                            input logic        hex);
    logic [31:0] r;
    logic [31:0] keep;
    keep = wide ? KPD_DEC_KEEP_WIDE : KPD_DEC_KEEP_NARROW;
    if (hex) begin
      r = {val[27:0], d};
    end else begin
      r = (val % keep) * KPD_DEC_BASE + {28'h0, d};
    end
    if (!wide) begin
      r = {16'h0, r[15:0]};
    end
    return r;
  endfunction : kpd_accum

  // ==========================================================
  // Next-state logic
  logic [4:0]  ten_hit;
  logic [4:0]  mat_hit;
  logic [4:0]  func_held;
  logic [15:0] mat_new;
  logic [15:0] sampled;
  logic        addr_ok;
  logic        scan_end;
  logic [3:0]  ctrl_now;

  always_comb begin
    next_st   = st;
    ten_hit   = 5'h00;
    mat_hit   = 5'h00;
    func_held = 5'h00;
    mat_new   = 16'h0000;
    sampled   = st.mat_cur;
    scan_end  = 1'b0;
    ctrl_now  = st.ctrl;

    // ========================================================
    // Bus slave: zero wait states, registered read data
    next_st.hreadyout = 1'b1;
    next_st.wr_pend   = 1'b0;
    if (st.wr_pend && st.wr_addr == KPD_CTRL_ADDR) begin
      ctrl_now     = HWDATA[3:0];
      next_st.ctrl = HWDATA[3:0];
    end
    addr_ok = HSEL && HREADY && HTRANS[1];
    if (addr_ok && HWRITE) begin
      next_st.wr_pend = 1'b1;
      next_st.wr_addr = HADDR[7:0];
    end
    if (addr_ok && !HWRITE) begin
      // Unmapped words read zero; forwarding covers write-then-read
      case (HADDR[7:0])
        KPD_CTRL_ADDR:    next_st.hrdata = {28'h0, ctrl_now};
        KPD_TEN_VAL_ADDR: next_st.hrdata = st.ten_val;
        KPD_TEN_IND_ADDR: next_st.hrdata = {21'h0, st.ten_ind};
        KPD_MAT_VAL_ADDR: next_st.hrdata = st.mat_val;
        KPD_MAT_IND_ADDR: next_st.hrdata = {24'h0, st.mat_ind};
        KPD_STATUS_ADDR:  next_st.hrdata = {29'h0, st.col, st.done};
        default:          next_st.hrdata = 32'h0;
      endcase
    end

    // ========================================================
    // Ten-key part
    next_st.ten_prev = TEN_KEY;
    if (st.ctrl[KPD_CTRL_TEN_EN]) begin
      ten_hit = kpd_lowest({6'h0, TEN_KEY & ~st.ten_prev});
      if (ten_hit[4]) begin
        next_st.ten_val = kpd_accum(st.ten_val, ten_hit[3:0],
                                    st.ctrl[KPD_CTRL_WIDE], 1'b0);
        next_st.ten_ind[9:0] = 10'(16'h0001 << ten_hit[3:0]);
      end
      next_st.ten_ind[10] = |TEN_KEY;
    end else begin
      next_st.ten_ind = 11'h000;
    end

    // ========================================================
    // Matrix scanner
    if (st.ctrl[KPD_CTRL_MAT_EN]) begin
      next_st.col_out = 4'(4'h1 << st.col);
      if (st.step_cnt == KPD_STEP_LAST) begin
        next_st.step_cnt = 7'h00;
        // Key index is line*4 + input; sampled at the end of the step
        sampled[{st.col, 2'b00} +: 4] = MATRIX_IN;
        next_st.mat_cur = sampled;
        next_st.col     = st.col + 2'd1;
        if (st.done) begin
          next_st.done = 1'b0;
        end
        if (st.col == 2'd3) begin
          scan_end = 1'b1;
        end
      end else begin
        next_st.step_cnt = st.step_cnt + 7'h01;
      end
    end else begin
      next_st.col_out  = 4'h0;
      next_st.step_cnt = 7'h00;
      next_st.col      = 2'd0;
      next_st.done     = 1'b0;
      next_st.mat_cur  = 16'h0000;
      next_st.mat_prev = 16'h0000;
      next_st.mat_ind  = 8'h00;
    end

    // ========================================================
    // Matrix key processing, once per completed rotation
    if (scan_end) begin
      next_st.done     = 1'b1;
      next_st.mat_prev = sampled;
      mat_new = sampled & ~st.mat_prev;
      mat_hit = kpd_lowest(mat_new);
      // A latched function key still held blocks newer ones
      func_held = kpd_lowest({sampled[15:10] & st.mat_ind[5:0], 10'h000});
      if (mat_hit[4]) begin
        if (st.ctrl[KPD_CTRL_HEX] || mat_hit[3:0] < 4'ha) begin
          next_st.mat_val = kpd_accum(st.mat_val, mat_hit[3:0],
                                      st.ctrl[KPD_CTRL_WIDE],
                                      st.ctrl[KPD_CTRL_HEX]);
        end
      end
      if (!st.ctrl[KPD_CTRL_HEX] && !func_held[4]) begin
        mat_hit = kpd_lowest({mat_new[15:10], 10'h000});
        if (mat_hit[4]) begin
          next_st.mat_ind[5:0] = 6'(16'h0001 << (mat_hit[3:0] - 4'ha));
        end
      end
      if (st.ctrl[KPD_CTRL_HEX]) begin
        next_st.mat_ind[5:0] = 6'h00;
      end
      next_st.mat_ind[KPD_IND_ANY_FUNC]  = |sampled[15:10];
      next_st.mat_ind[KPD_IND_ANY_DIGIT] = |sampled[9:0];
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st           <= '0;
      st.ctrl      <= KPD_CTRL_RESET;
      st.hreadyout <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    HRDATA        = st.hrdata;
    HREADYOUT     = st.hreadyout;
    HRESP         = 1'b0;
    MATRIX_OUT    = st.col_out;
    SCAN_COMPLETE = st.done;
  end

endmodule : kpd_decoder

`default_nettype wire

// ==== kpd_decoder_checker.sv ====
// Purpose: Port assertions for kpd_decoder
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to every kpd_decoder instance
`timescale 1ns/10ps
`default_nettype none
module kpd_decoder_checker
  import kpd_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        HSEL,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic [3:0]  MATRIX_OUT,
  input wire logic        SCAN_COMPLETE
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  // ==========================================================
  // Run lengths: too long for a repetition operator
  logic [3:0] prev_line;
  logic [6:0] line_cnt;
  logic [7:0] pulse_cnt;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      prev_line <= 4'h0;
      line_cnt  <= 7'h0;
      pulse_cnt <= 8'h0;
    end else begin
      prev_line <= MATRIX_OUT;
      line_cnt  <= (MATRIX_OUT != prev_line) ? 7'h0 : line_cnt + 7'h1;
      pulse_cnt <= SCAN_COMPLETE ? pulse_cnt + 8'h1 : 8'h0;
    end
  end
  sequence line_moved;
    MATRIX_OUT != prev_line && prev_line != 4'h0 && MATRIX_OUT != 4'h0;
  endsequence
  // ==========================================================
  // Assertions
  ready_always_a: assert property (HREADYOUT == 1'b1)
    else $error("Bus ready dropped");
  resp_okay_a: assert property (HRESP == 1'b0)
    else $error("Bus response not okay");
  line_onehot_a: assert property ($onehot0(MATRIX_OUT))
    else $error("More than one drive line active");
  line_rotate_a: assert property (line_moved |-> MATRIX_OUT == {prev_line[2:0], prev_line[3]})
    else $error("Drive line out of rotation");
  step_length_a: assert property (line_moved |-> line_cnt == KPD_STEP_LAST)
    else $error("Scan step length wrong");
  scan_after_a: assert property ($rose(SCAN_COMPLETE) |-> prev_line == 4'h8)
    else $error("Scan flag not after last line");
  scan_len_a: assert property ($fell(SCAN_COMPLETE) && MATRIX_OUT != 4'h0
    |-> pulse_cnt == 8'(KPD_STEP_CYCLES))
    else $error("Scan flag length wrong");
  rdata_hold_a: assert property (!(HSEL && HREADY && HTRANS[1] && !HWRITE) |=> $stable(HRDATA))
    else $error("Read data changed without a read");
endmodule : kpd_decoder_checker
bind kpd_decoder kpd_decoder_checker chk_i (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MATRIX_OUT(MATRIX_OUT),
  .SCAN_COMPLETE(SCAN_COMPLETE));
`default_nettype wire

// ==== kpd_keypad_model.sv ====
// Purpose: Sixteen push buttons at the matrix crossings
// Assumes: Active-high drive lines
// Notes:   Unselected read lines sit low through pull-downs
`timescale 1ns/10ps
`default_nettype none
module kpd_keypad_model (
  input  wire logic [3:0]  line,
  input  wire logic [15:0] keys,
  output var  logic [3:0]  sense
);
  always_comb begin
    sense = 4'h0;
    for (int c = 0; c < 4; c++) begin
      if (line[c]) sense = sense | keys[c*4 +: 4];
    end
  end
endmodule : kpd_keypad_model
`default_nettype wire

// ==== kpd_decoder_test.sv ====
// Purpose: Self-checking bench for kpd_decoder
// Assumes: Zero-wait AHB-Lite slave
// Notes:   Matrix keys change only at the start of a rotation
`timescale 1ns/10ps
`default_nettype none
module kpd_decoder_test
  import kpd_pkg::*;
;
  logic        CLK = 0, RESET_N = 0, HSEL = 0, HWRITE = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, rdata;
  logic [1:0]  HTRANS = 0;
  logic [9:0]  TEN_KEY = 0;
  logic [15:0] keys = 0;
  wire logic [31:0] HRDATA;
  wire logic HREADYOUT, HRESP, SCAN_COMPLETE;
  wire logic [3:0] MATRIX_IN, MATRIX_OUT;
  int miscompares = 0, compares = 0, cycles = 0;
  always #4 CLK = ~CLK;
  kpd_decoder uut (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .TEN_KEY(TEN_KEY), .MATRIX_IN(MATRIX_IN), .MATRIX_OUT(MATRIX_OUT),
    .SCAN_COMPLETE(SCAN_COMPLETE));
  kpd_keypad_model kp (.line(MATRIX_OUT), .keys(keys), .sense(MATRIX_IN));
  // ==========================================================
  // Shared tasks
  task final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= {24'h0, a};
    do @(posedge CLK); while (!HREADYOUT);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (!HREADYOUT);
    rdata = HRDATA;
  endtask : xfer
  task tkey(input int d);
    @(posedge CLK);
    TEN_KEY <= 10'h1 << d;
    repeat (3) @(posedge CLK);
    TEN_KEY <= 10'h0;
  endtask : tkey
  // Press a key set at a rotation start, return once it is processed
  task mkey(input logic [15:0] m);
    while (SCAN_COMPLETE) @(negedge CLK);
    while (!SCAN_COMPLETE) @(negedge CLK);
    @(posedge CLK);
    keys <= m;
    while (SCAN_COMPLETE) @(negedge CLK);
    while (!SCAN_COMPLETE) @(negedge CLK);
  endtask : mkey
  // ==========================================================
  // Scenarios
  task t_regs;
    xfer(0, 8'h18, 0); chk(rdata, 0);
    xfer(1, KPD_TEN_IND_ADDR, 32'hffff_ffff);
    xfer(0, KPD_TEN_IND_ADDR, 0); chk(rdata, 0);
  endtask : t_regs
  task t_ten;
    xfer(1, KPD_CTRL_ADDR, 32'h1);
    tkey(5); tkey(3); tkey(0); tkey(1);
    xfer(0, KPD_TEN_VAL_ADDR, 0); chk(rdata, 32'h14b5);
    @(posedge CLK) TEN_KEY <= 10'h004;
    xfer(0, KPD_TEN_IND_ADDR, 0); chk(rdata, 32'h404);
    @(posedge CLK) TEN_KEY <= 10'h0;
    xfer(0, KPD_TEN_IND_ADDR, 0); chk(rdata, 32'h004);
    xfer(0, KPD_TEN_VAL_ADDR, 0); chk(rdata, 32'hbc4);
    xfer(1, KPD_CTRL_ADDR, 32'h0);
    xfer(0, KPD_TEN_IND_ADDR, 0); chk(rdata, 0);
    xfer(0, KPD_TEN_VAL_ADDR, 0); chk(rdata, 32'hbc4);
    xfer(1, KPD_CTRL_ADDR, 32'h5);
    for (int d = 1; d < 10; d++) tkey(d);
    xfer(0, KPD_TEN_VAL_ADDR, 0); chk(rdata, 32'h0165_ec15);
  endtask : t_ten
  task t_mat;
    xfer(1, KPD_CTRL_ADDR, 32'ha);
    mkey(16'h1020); mkey(16'h0);
    xfer(0, KPD_MAT_VAL_ADDR, 0); chk(rdata, 32'h5);
    mkey(16'h1000); mkey(16'h0);
    xfer(0, KPD_MAT_VAL_ADDR, 0); chk(rdata, 32'h5c);
    xfer(1, KPD_CTRL_ADDR, 32'h2);
    mkey(16'h0400); mkey(16'h2400);
    xfer(0, KPD_MAT_IND_ADDR, 0); chk(rdata, 32'h41);
    mkey(16'h0); mkey(16'h2000); mkey(16'h0);
    xfer(0, KPD_MAT_IND_ADDR, 0); chk(rdata, 32'h8);
    mkey(16'h0080);
    xfer(0, KPD_MAT_IND_ADDR, 0); chk(rdata, 32'h88);
    mkey(16'h0);
    xfer(0, KPD_MAT_VAL_ADDR, 0); chk(rdata, 32'h39f);
    xfer(1, KPD_CTRL_ADDR, 32'h0);
    xfer(0, KPD_MAT_IND_ADDR, 0); chk(rdata, 0);
    xfer(0, KPD_MAT_VAL_ADDR, 0); chk(rdata, 32'h39f);
    // Wide form keeps a fifth digit, narrow form keeps only the last four
    xfer(1, KPD_CTRL_ADDR, 32'h6);
    mkey(16'h0010); mkey(16'h0);
    mkey(16'h0020); mkey(16'h0);
    xfer(0, KPD_MAT_VAL_ADDR, 0); chk(rdata, 32'h0001_6a49);
    xfer(1, KPD_CTRL_ADDR, 32'h2);
    mkey(16'h0001); mkey(16'h0);
    xfer(0, KPD_MAT_VAL_ADDR, 0); chk(rdata, 32'h1d1a);
  endtask : t_mat
  // ==========================================================
  // Main sequence and hang guard
  initial begin
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    t_regs;
    t_ten;
    t_mat;
    final_report;
  end
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      final_report;
    end
  end
endmodule : kpd_decoder_test
`default_nettype wire
